// ==== wwd_core.sv ====
/*
 Windowed watchdog timer: control and status registers, keyed change window,
 lock, restart and control synchronisation, and the timeout state machine.
 Assumes a 10 MHz clk, a 1 kHz counter clock pin, and a core that pulses the
 restart input for one cycle per restart instruction.
*/
`timescale 1ns/1ps
`default_nettype none

module wwd_core #(
    parameter logic [7:0] CHANGE_KEY = 8'h5a // Arbitrary value.
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Core
    input wire logic watchdog_restart_instruction,
    // Pins and straps
    input wire logic watchdog_counter_clock,
    input wire logic debug_mode,
    input wire logic [7:0] fuse_control,
    // Results
    output logic system_reset,
    output logic sync_pending_flag
);

    wwd_tick_if tick_bus ();

    logic dbg_s1_q, dbg_s2_q;
    logic [7:0] fuse_s1_q, fuse_s2_q;
    logic [1:0] boot_q, boot_d;
    logic [2:0] key_cnt_q, key_cnt_d;
    logic lock_q, lock_d;
    logic [7:0] ctrl_pend_q, ctrl_pend_d;
    logic ctrl_busy_q, ctrl_busy_d;
    logic [1:0] ctrl_ticks_q, ctrl_ticks_d;
    logic rst_busy_q, rst_busy_d;
    logic [1:0] rst_ticks_q, rst_ticks_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] ctrl_q, ctrl_d;
    wwd_pkg::wwd_state_t state_q, state_d;
    logic [13:0] cnt_q, cnt_d;
    logic sys_reset_q, sys_reset_d;

    logic tick;
    logic boot_load;
    logic key_open;
    logic ctrl_accept;
    logic ctrl_apply;
    logic restart_accept;
    logic restart_apply;
    logic [13:0] period_len;
    logic [13:0] window_len;
    logic fire;

    wwd_tick_gen u_tick_gen (
        .clk(clk),
        .resetn(resetn),
        .counter_clock(watchdog_counter_clock),
        .tick_port(tick_bus.src)
    );

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dbg_s1_q <= 1'b0;
            dbg_s2_q <= 1'b0;
            fuse_s1_q <= wwd_pkg::CONTROL_RESET;
            fuse_s2_q <= wwd_pkg::CONTROL_RESET;
        end
        else
        begin
            dbg_s1_q <= debug_mode;
            dbg_s2_q <= dbg_s1_q;
            fuse_s1_q <= fuse_control;
            fuse_s2_q <= fuse_s1_q;
        end
    end

    // ========================================================================
    // Shared decodes
    // ========================================================================
    always_comb
    begin
        tick = tick_bus.tick;
        boot_load = (boot_q == 2'h2);
        key_open = (key_cnt_q != 3'h0);
        ctrl_accept = reg_write && (reg_addr == wwd_pkg::OFF_CONTROL) && key_open
                      && !lock_q && !ctrl_busy_q && (boot_q == 2'h3);
        ctrl_apply = tick && ctrl_busy_q && (ctrl_ticks_q == wwd_pkg::SYNC_TICKS);
        restart_accept = watchdog_restart_instruction && !rst_busy_q && (boot_q == 2'h3);
        restart_apply = tick && rst_busy_q && (rst_ticks_q == wwd_pkg::SYNC_TICKS);
        period_len = wwd_pkg::wwd_code_len(ctrl_q[wwd_pkg::CTRL_PERIOD_LSB +: 4]);
        window_len = wwd_pkg::wwd_code_len(ctrl_q[wwd_pkg::CTRL_WINDOW_LSB +: 4]);
    end

    // ========================================================================
    // Register side
    // ========================================================================
    always_comb
    begin
        boot_d = (boot_q == 2'h3) ? boot_q : boot_q + 2'h1;
        key_cnt_d = key_open ? key_cnt_q - 3'h1 : 3'h0;
        lock_d = lock_q;
        ctrl_pend_d = ctrl_pend_q;
        ctrl_busy_d = ctrl_busy_q;
        ctrl_ticks_d = ctrl_ticks_q;
        rst_busy_d = rst_busy_q;
        rst_ticks_d = rst_ticks_q;
        rdata_d = wwd_pkg::READ_IDLE;
        if (reg_write && (reg_addr == wwd_pkg::OFF_CHANGE_KEY) && (reg_wdata == CHANGE_KEY))
        begin
            key_cnt_d = wwd_pkg::KEY_WINDOW_CYCLES;
        end
        if (boot_load)
        begin
            ctrl_pend_d = fuse_s2_q;
            lock_d = (fuse_s2_q[wwd_pkg::CTRL_PERIOD_LSB +: 4] != 4'h0);
        end
        else if (reg_write && (reg_addr == wwd_pkg::OFF_STATUS) && key_open)
        begin
            if (reg_wdata[wwd_pkg::STATUS_LOCK_BIT])
            begin
                lock_d = 1'b1;
            end
            else if (dbg_s2_q)
            begin
                lock_d = 1'b0;
            end
        end
        if (ctrl_accept)
        begin
            ctrl_pend_d = reg_wdata;
            ctrl_busy_d = 1'b1;
            ctrl_ticks_d = 2'h0;
        end
        else if (ctrl_apply)
        begin
            ctrl_busy_d = 1'b0;
        end
        else if (tick && ctrl_busy_q)
        begin
            ctrl_ticks_d = ctrl_ticks_q + 2'h1;
        end
        if (restart_accept)
        begin
            rst_busy_d = 1'b1;
            rst_ticks_d = 2'h0;
        end
        else if (restart_apply)
        begin
            rst_busy_d = 1'b0;
        end
        else if (tick && rst_busy_q)
        begin
            rst_ticks_d = rst_ticks_q + 2'h1;
        end
        if (reg_read)
        begin
            case (reg_addr)
                wwd_pkg::OFF_CONTROL: rdata_d = ctrl_pend_q;
                wwd_pkg::OFF_STATUS: rdata_d = {lock_q, 6'h00, ctrl_busy_q};
                default: rdata_d = wwd_pkg::READ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            boot_q <= 2'h0;
            key_cnt_q <= 3'h0;
            lock_q <= 1'b0;
            ctrl_pend_q <= wwd_pkg::CONTROL_RESET;
            ctrl_busy_q <= 1'b0;
            ctrl_ticks_q <= 2'h0;
            rst_busy_q <= 1'b0;
            rst_ticks_q <= 2'h0;
            rdata_q <= wwd_pkg::READ_IDLE;
        end
        else
        begin
            boot_q <= boot_d;
            key_cnt_q <= key_cnt_d;
            lock_q <= lock_d;
            ctrl_pend_q <= ctrl_pend_d;
            ctrl_busy_q <= ctrl_busy_d;
            ctrl_ticks_q <= ctrl_ticks_d;
            rst_busy_q <= rst_busy_d;
            rst_ticks_q <= rst_ticks_d;
            rdata_q <= rdata_d;
        end
    end

    // ========================================================================
    // Timeout state machine
    // ========================================================================
    // Counting advances on the counter clock tick, but every register runs on clk, so a stopped clk stops it; debug mode holds the count at zero.
    always_comb
    begin
        ctrl_d = ctrl_q;
        state_d = state_q;
        cnt_d = cnt_q;
        fire = 1'b0;
        if (boot_load)
        begin
            ctrl_d = fuse_s2_q;
            state_d = wwd_pkg::wwd_mode_of(fuse_s2_q);
            cnt_d = 14'h0000;
        end
        else if (ctrl_apply)
        begin
            ctrl_d = ctrl_pend_q;
            state_d = wwd_pkg::wwd_mode_of(ctrl_pend_q);
            cnt_d = 14'h0000;
        end
        else if (dbg_s2_q)
        begin
            cnt_d = 14'h0000;
            if ((state_q == wwd_pkg::ST_CLOSED) || (state_q == wwd_pkg::ST_OPEN))
            begin
                state_d = wwd_pkg::ST_WAIT_FIRST;
            end
        end
        else if (tick)
        begin
            case (state_q)
                wwd_pkg::ST_OFF:
                begin
                    cnt_d = 14'h0000;
                end
                wwd_pkg::ST_NORMAL, wwd_pkg::ST_WAIT_FIRST, wwd_pkg::ST_OPEN:
                begin
                    if (restart_apply)
                    begin
                        cnt_d = 14'h0000;
                        if (state_q != wwd_pkg::ST_NORMAL)
                        begin
                            state_d = wwd_pkg::ST_CLOSED;
                        end
                    end
                    else if (cnt_q == period_len - 14'h0001)
                    begin
                        fire = 1'b1;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 14'h0001;
                    end
                end
                wwd_pkg::ST_CLOSED:
                begin
                    if (restart_apply)
                    begin
                        fire = 1'b1;
                    end
                    else if (cnt_q == window_len - 14'h0001)
                    begin
                        state_d = wwd_pkg::ST_OPEN;
                        cnt_d = 14'h0000;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 14'h0001;
                    end
                end
                default:
                begin
                    state_d = wwd_pkg::ST_OFF;
                    cnt_d = 14'h0000;
                end
            endcase
        end
        sys_reset_d = sys_reset_q || fire;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q <= wwd_pkg::CONTROL_RESET;
            state_q <= wwd_pkg::ST_OFF;
            cnt_q <= 14'h0000;
            sys_reset_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            sys_reset_q <= sys_reset_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign system_reset = sys_reset_q;
    assign sync_pending_flag = ctrl_busy_q;

    // ========================================================================
    // Checks
    // ========================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_restart_due;
        tick && rst_busy_q && (rst_ticks_q == wwd_pkg::SYNC_TICKS) && !ctrl_apply && !dbg_s2_q && !boot_load;
    endsequence

    sequence s_ctrl_taken;
        reg_write && (reg_addr == wwd_pkg::OFF_CONTROL) && key_open && !lock_q && !ctrl_busy_q && (boot_q == 2'h3);
    endsequence

    a_timeout_reset_fires:
    assert property ((state_q == wwd_pkg::ST_NORMAL) && tick && !restart_apply && !ctrl_apply && !dbg_s2_q
                     && (cnt_q + 14'h0001 == period_len) |=> system_reset ##1 system_reset)
    else $error("missed timeout did not raise system reset");

    a_restart_extra_ignored:
    assert property (rst_busy_q && watchdog_restart_instruction && !tick |=> rst_busy_q
                     && (rst_ticks_q == $past(rst_ticks_q)))
    else $error("restart during synchronisation was not ignored");

    a_restart_restarts:
    assert property (s_restart_due ##0 (state_q == wwd_pkg::ST_NORMAL) |=> (cnt_q == 14'h0000) && !rst_busy_q)
    else $error("restart did not clear the running count");

    a_closed_early_reset:
    assert property (s_restart_due ##0 (state_q == wwd_pkg::ST_CLOSED) |=> system_reset)
    else $error("restart in closed period did not reset");

    a_open_follows_closed:
    assert property ((state_q == wwd_pkg::ST_CLOSED) && tick && !restart_apply && !ctrl_apply && !dbg_s2_q
                     && (cnt_q + 14'h0001 == window_len) |=> (state_q == wwd_pkg::ST_OPEN) && (cnt_q == 14'h0000))
    else $error("open period did not follow closed period");

    a_first_restart_closes:
    assert property (s_restart_due ##0 (state_q == wwd_pkg::ST_WAIT_FIRST) |=> (state_q == wwd_pkg::ST_CLOSED))
    else $error("first restart did not start closed period");

    a_lock_holds_ctrl:
    assert property (lock_q && !dbg_s2_q && (boot_q == 2'h3) |=> lock_q && $stable(ctrl_pend_q))
    else $error("locked settings changed");

    a_ctrl_keyed_only:
    assert property (reg_write && (reg_addr == wwd_pkg::OFF_CONTROL) && !key_open && (boot_q == 2'h3) && !lock_q
                     |=> $stable(ctrl_pend_q))
    else $error("control changed without change key");

    a_ctrl_sync_delay:
    assert property (s_ctrl_taken |=> ctrl_busy_q && $stable(ctrl_q) ##1 $stable(ctrl_q))
    else $error("control write took effect before synchronisation");

    a_off_no_reset:
    assert property ((state_q == wwd_pkg::ST_OFF) && !sys_reset_q |=> !sys_reset_q)
    else $error("disabled watchdog raised system reset");

endmodule : wwd_core

`default_nettype wire

// ==== wwd_pkg.sv ====
/*
 Constants, types and helper functions of the windowed watchdog timer.
 Assumes a 10 MHz system clock and a 1 kHz watchdog counter clock on a pin.
*/
`default_nettype none

package wwd_pkg;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CNT_CLK_HZ = 1_000;
    localparam int unsigned CNT_CLK_PERIOD_CLKS = CLK_HZ / CNT_CLK_HZ;
    localparam logic [1:0] SYNC_TICKS = 2'h2;
    localparam logic [2:0] KEY_WINDOW_CYCLES = 3'h4;
    localparam logic [3:0] CODE_MAX = 4'hb;
    localparam logic [13:0] LEN_BASE = 14'h0008;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h01;
    localparam logic [7:0] OFF_CHANGE_KEY = 8'h02;
    localparam int unsigned CTRL_PERIOD_LSB = 0;
    localparam int unsigned CTRL_WINDOW_LSB = 4;
    localparam int unsigned STATUS_SYNC_BIT = 0;
    localparam int unsigned STATUS_LOCK_BIT = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [4:0] {
        ST_OFF = 5'b00001,
        ST_NORMAL = 5'b00010,
        ST_WAIT_FIRST = 5'b00100,
        ST_CLOSED = 5'b01000,
        ST_OPEN = 5'b10000
    } wwd_state_t;

    // ========================================================================
    // Functions
    // ========================================================================
    // Length in counter ticks of a period or window code; reserved codes act as the longest.
    function automatic logic [13:0] wwd_code_len(input logic [3:0] code);
        logic [3:0] c;
        c = (code > CODE_MAX) ? CODE_MAX : code;
        if (c == 4'h0)
        begin
            c = 4'h1;
        end
        return LEN_BASE << (c - 4'h1);
    endfunction : wwd_code_len

    // Operating state selected by a control value.
    function automatic wwd_state_t wwd_mode_of(input logic [7:0] ctrl);
        if (ctrl[CTRL_PERIOD_LSB +: 4] == 4'h0)
        begin
            return ST_OFF;
        end
        else if (ctrl[CTRL_WINDOW_LSB +: 4] != 4'h0)
        begin
            return ST_WAIT_FIRST;
        end
        return ST_NORMAL;
    endfunction : wwd_mode_of

endpackage : wwd_pkg

`default_nettype wire

// ==== wwd_tick_if.sv ====
/*
 Interface that carries the counter clock tick from its synchroniser to the core.
 Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface wwd_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface : wwd_tick_if

`default_nettype wire

// ==== wwd_tick_gen.sv ====
/*
 Brings the 1 kHz watchdog counter clock pin into the system clock domain
 and turns each rising edge into a one-cycle tick.
 Assumes the system clock is much faster than the counter clock.
*/
`timescale 1ns/1ps
`default_nettype none

module wwd_tick_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Counter clock pin
    input wire logic counter_clock,
    // Tick out
    wwd_tick_if.src tick_port
);

    logic s1_q, s1_d;
    logic s2_q, s2_d;
    logic s3_q, s3_d;
    logic tick_q, tick_d;
    logic [1:0] warm_q, warm_d;

    // ========================================================================
    // Synchroniser and edge detector
    // ========================================================================
    always_comb
    begin
        s1_d = counter_clock;
        s2_d = s1_q;
        s3_d = s2_q;
        // Edge detection waits until all three stages hold real pin samples, so a high pin at release is no tick.
        warm_d = (warm_q == 2'h3) ? warm_q : warm_q + 2'h1;
        tick_d = s2_q && !s3_q && (warm_q == 2'h3);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            tick_q <= 1'b0;
            warm_q <= 2'h0;
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            tick_q <= tick_d;
            warm_q <= warm_d;
        end
    end

    assign tick_port.tick = tick_q;

    // ========================================================================
    // Checks
    // ========================================================================
    a_tick_single_cycle:
    assert property (@(posedge clk) disable iff (!resetn) tick_q |=> !tick_q ##1 !tick_q)
    else $error("counter tick lasted or repeated too soon");

endmodule : wwd_tick_gen

`default_nettype wire

// ==== wwd_cpu_model.sv ====
/*
 Model of the processor core that issues watchdog restart instructions.
 Assumes the bench pulses fire for one clk cycle and waits for the pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module wwd_cpu_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Bench request and delay in clk cycles
    input wire logic fire,
    input wire logic [3:0] gap,
    // Restart pulse to the watchdog
    output logic restart
);
    // ========================================================================
    // Delayed one-cycle restart pulse
    // ========================================================================
    logic [4:0] cnt_q;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_q <= 5'h00;
            restart <= 1'b0;
        end
        else
        begin
            restart <= (cnt_q == 5'h01);
            if (fire)
            begin
                cnt_q <= {1'b0, gap} + 5'h01;
            end
            else if (cnt_q != 5'h00)
            begin
                cnt_q <= cnt_q - 5'h01;
            end
        end
    end
endmodule : wwd_cpu_model

`default_nettype wire

// ==== tb_top.sv ====
/*
 Self-checking bench of the windowed watchdog core.
 Assumes a 10 MHz clk and a counter clock shortened to ten clk cycles a tick.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam logic [7:0] KEY = 8'h5a;
    logic clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic cclk = 1'b0, debug_mode = 1'b0, fire = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, fuse_control = 8'h00;
    logic [3:0] gap = 4'h0;
    logic [7:0] reg_rdata;
    logic system_reset, sync_pending_flag, restart;
    logic [31:0] seed = 32'hf939df34;
    logic [31:0] r;
    int n_fail = 0, comparisons = 0, ctrl_m = 0, lock_m = 0, cdiv = 0, p, len, n;

    // ========================================================================
    // Clocks and instances
    // ========================================================================
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        cdiv <= (cdiv == 4) ? 0 : cdiv + 1;
        if (cdiv == 4)
        begin
            cclk <= ~cclk;
        end
    end

    wwd_core #(.CHANGE_KEY(KEY)) dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .watchdog_restart_instruction(restart), .watchdog_counter_clock(cclk),
        .debug_mode(debug_mode), .fuse_control(fuse_control), .system_reset(system_reset),
        .sync_pending_flag(sync_pending_flag));
    wwd_cpu_model cpu (.clk(clk), .resetn(resetn), .fire(fire), .gap(gap), .restart(restart));

    // ========================================================================
    // Helpers
    // ========================================================================
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        if (n_fail == 0 && comparisons > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic rst(input logic [7:0] f);
        @(posedge clk);
        resetn <= 1'b0;
        fuse_control <= f;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        ctrl_m = f;
        lock_m = (f[3:0] != 4'h0);
    endtask : rst

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    // Keyed write; the model follows the lock and debug rules.
    task automatic kwr(input logic [7:0] a, input logic [7:0] d);
        wr(8'h02, KEY);
        wr(a, d);
        if (a == 8'h00 && lock_m == 0)
        begin
            ctrl_m = d;
        end
        if (a == 8'h01 && d[7])
        begin
            lock_m = 1;
        end
        else if (a == 8'h01 && debug_mode)
        begin
            lock_m = 0;
        end
    endtask : kwr

    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = (a == 8'h00) ? ctrl_m[7:0] : (a == 8'h01) ? {lock_m[0], 7'h00} : 8'h00;
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        check("rdata", reg_rdata, e);
        @(negedge clk);
        check("rdata_idle", reg_rdata, 8'h00);
    endtask : rd

    task automatic ticks(input int k);
        repeat (k) @(posedge cclk);
        @(negedge clk);
    endtask : ticks

    task automatic rs(input logic [3:0] g);
        @(posedge clk);
        fire <= 1'b1;
        gap <= g;
        @(posedge clk);
        fire <= 1'b0;
        repeat (g + 3) @(posedge clk);
    endtask : rs

    // No control write is made while synchronisation is busy.
    task automatic wait_sync();
        @(negedge clk);
        n = 0;
        while (sync_pending_flag === 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        check("sync_done", sync_pending_flag, 1'b0);
    endtask : wait_sync

    // ========================================================================
    // Scenarios
    // ========================================================================
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end

    initial
    begin
        rst(8'h00);
        rd(8'h00);
        rd(8'h01);
        r = rnd();
        wr({1'b1, r[14:8]}, r[23:16]);
        rd({1'b1, r[6:0]});
        wr(8'h00, 8'h01);
        rd(8'h00);
        rs(4'h9);
        ticks(20);
        check("off", system_reset, 1'b0);
        p = 1 + r[24];
        len = 8 << (p - 1);
        kwr(8'h00, p[7:0]);
        @(negedge clk);
        check("busy", sync_pending_flag, 1'b1);
        rd(8'h00);
        wait_sync();
        n = 0;
        while (system_reset !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        check("timeout", (n >= (len - 1) * 10 - 3) && (n <= len * 10 + 3), 1'b1);
        rst(8'h00);
        kwr(8'h00, 8'h12);
        wait_sync();
        ticks(5);
        rs(4'h0);
        ticks(4);
        check("first_open", system_reset, 1'b0);
        rs(4'h0);
        ticks(5);
        check("early", system_reset, 1'b1);
        rst(8'h00);
        kwr(8'h00, 8'h12);
        wait_sync();
        rs(4'h0);
        ticks(1);
        rs(4'h9);
        ticks(11);
        rs(4'h0);
        ticks(4);
        check("in_window", system_reset, 1'b0);
        ticks(16);
        check("open_run", system_reset, 1'b0);
        ticks(10);
        check("late", system_reset, 1'b1);
        rst(8'h00);
        kwr(8'h01, 8'h80);
        rd(8'h01);
        kwr(8'h00, 8'h01);
        rd(8'h00);
        kwr(8'h01, 8'h00);
        rd(8'h01);
        @(posedge clk);
        debug_mode <= 1'b1;
        repeat (4) @(posedge clk);
        kwr(8'h01, 8'h00);
        rd(8'h01);
        @(posedge clk);
        debug_mode <= 1'b0;
        rst(8'h01);
        rd(8'h00);
        rd(8'h01);
        rs(4'h0);
        ticks(8);
        check("fuse_run", system_reset, 1'b0);
        ticks(8);
        check("fuse_timeout", system_reset, 1'b1);
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
